// ---- mmi_pkg.sv ----
// constants, register map and state encoding for the multi-master two-wire controller
//
// Overview of operation
// RULE_01: No read-modify-write on data register mid-transfer.
// RULE_02: Stop detection clears own-address read/write match bit.
// RULE_03: Status bits hardware-updated; software avoids read-modify-write.
// RULE_04: Start and byte completion reset bit-count field.
// RULE_05: Bit-rate register is never changed by hardware.
// RULE_06: Master start: check busy, write address, write F0.
// RULE_07: Interrupts off across busy check, address, start.
// RULE_08: Bus busy means abandon start, re-enable interrupts.
// RULE_09: Restart: pending bit zero, write 00, never set pending.
// RULE_10: Slave receive select clears direction, releases data line.
// RULE_11: Data write during restart sequence releases clock line.
// RULE_12: Address write then F0 triggers the repeated start.
// RULE_13: Stop: write C0, idle, D0 within ten cycles.
// RULE_14: Never set pending while clearing role and direction.
// RULE_15: Never clear role and direction while pending set.
// RULE_16: After stop, no data/status writes until idle.
// RULE_17: Register reads have no side effects on stop.
// RULE_18: Stop seen in slave role raises bus interrupt.
// RULE_19: Busy flag set on start, cleared on stop.
package mmi_pkg;

  localparam int unsigned CLK_MHZ    = 40;
  localparam int unsigned PHI_NS     = 250;
  localparam int unsigned PHI_CYC    = (PHI_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W      = 16;

  localparam logic [4:0] OFS_DATA    = 5'h00;
  localparam logic [4:0] OFS_OWN     = 5'h04;
  localparam logic [4:0] OFS_STAT    = 5'h08;
  localparam logic [4:0] OFS_CTRL    = 5'h0C;
  localparam logic [4:0] OFS_RATE    = 5'h10;
  localparam logic [4:0] OFS_IRQ_ST  = 5'h14;
  localparam logic [4:0] OFS_IRQ_MSK = 5'h18;

  localparam int unsigned ST_MST     = 7;
  localparam int unsigned ST_TRX     = 6;
  localparam int unsigned ST_BB      = 5;
  localparam int unsigned ST_PIN     = 4;
  localparam int unsigned ST_AL      = 3;
  localparam int unsigned ST_LRB     = 0;
  localparam int unsigned CTL_EN     = 3;
  localparam int unsigned OWN_RW     = 0;
  localparam int unsigned RATE_DIV_W = 5;

  localparam int unsigned IRQ_W      = 3;
  localparam int unsigned IRQ_BYTE   = 0;
  localparam int unsigned IRQ_SSTOP  = 1;
  localparam int unsigned IRQ_AL     = 2;

  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [2:0] BC_LAST     = 3'h7;
  localparam logic [2:0] BC_ZERO     = 3'h0;
  localparam logic [2:0] BC_ONE      = 3'h1;

  typedef enum logic [3:0] {
    MMI_IDLE    = 4'h0,
    MMI_RSETUP  = 4'h1,
    MMI_START_H = 4'h3,
    MMI_START_L = 4'h2,
    MMI_BIT_L   = 4'h6,
    MMI_BIT_H   = 4'h7,
    MMI_ACK_L   = 4'h5,
    MMI_ACK_H   = 4'h4,
    MMI_HOLD    = 4'hC,
    MMI_STOP_L  = 4'hD,
    MMI_STOP_H  = 4'hF,
    MMI_REL     = 4'hE
  } mmi_state_t;

endpackage : mmi_pkg

// ---- mmi_line_mon.sv ----
// line synchroniser, start/stop detector and bus busy flag
`timescale 1ns/10ps
module mmi_line_mon
  import mmi_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_s_out,
  output logic      sda_s_out,
  output logic      start_det_out,
  output logic      stop_det_out,
  output logic      busy_out
);
  logic scl_m_ff;
  logic sda_m_ff;
  logic scl_s_ff;
  logic sda_s_ff;
  logic sda_p_ff;
  logic busy_ff;
  logic nxt_busy;
  logic start_c;
  logic stop_c;

  always_comb begin
    // only the second stage and its delayed copy feed the detector
    start_c  = scl_s_ff & sda_p_ff & ~sda_s_ff;
    stop_c   = scl_s_ff & ~sda_p_ff & sda_s_ff;
    nxt_busy = busy_ff;
    if (start_c) begin
      nxt_busy = 1'b1; // RULE_19
    end else if (stop_c) begin
      nxt_busy = 1'b0; // RULE_19
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scl_m_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_p_ff <= 1'b1;
      busy_ff  <= 1'b0;
    end else begin
      scl_m_ff <= scl_in;
      sda_m_ff <= sda_in;
      scl_s_ff <= scl_m_ff;
      sda_s_ff <= sda_m_ff;
      sda_p_ff <= sda_s_ff;
      busy_ff  <= nxt_busy;
    end
  end

  assign scl_s_out     = scl_s_ff;
  assign sda_s_out     = sda_s_ff;
  assign start_det_out = start_c;
  assign stop_det_out  = stop_c;
  assign busy_out      = busy_ff;
endmodule : mmi_line_mon

// ---- mmi_bit_timer.sv ----
// phase timer: one tick per bus half-period, set by the bit-rate divisor
`timescale 1ns/10ps
module mmi_bit_timer
  import mmi_pkg::*;
#(
  parameter int unsigned UNIT_CYC = PHI_CYC
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  restart_in,
  input  wire logic                  run_in,
  input  wire logic [RATE_DIV_W-1:0] div_in,
  output logic                       tick_out
);
  logic [TMR_W-1:0] cnt_ff;
  logic [TMR_W-1:0] nxt_cnt;
  logic [TMR_W-1:0] limit;

  always_comb begin
    limit    = TMR_W'((div_in + 1) * UNIT_CYC - 1);
    tick_out = run_in & (cnt_ff >= limit);
    nxt_cnt  = cnt_ff;
    if (restart_in || tick_out) begin
      nxt_cnt = '0;
    end else if (run_in) begin
      // counting pauses while a stretched clock is held low
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : mmi_bit_timer

// ---- mmi_ctrl.sv ----
// two-wire multi-master controller top with Avalon-MM register slave
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module mmi_ctrl
  import mmi_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  input  wire logic [3:0]  byteenable_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  output logic             bus_interrupt_request_out,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out
);
  mmi_state_t       state_ff;
  mmi_state_t       nxt_state;
  logic [7:0]       shift_ff;
  logic [7:0]       nxt_shift;
  logic [7:0]       own_ff;
  logic [7:0]       nxt_own;
  logic [7:0]       ctl_ff;
  logic [7:0]       nxt_ctl;
  logic [7:0]       rate_ff;
  logic [7:0]       nxt_rate;
  logic             mst_ff;
  logic             nxt_mst;
  logic             trx_ff;
  logic             nxt_trx;
  logic             pin_ff;
  logic             nxt_pin;
  logic             al_ff;
  logic             nxt_al;
  logic             lrb_ff;
  logic             nxt_lrb;
  logic             stop_pend_ff;
  logic             nxt_stop_pend;
  logic             scl_oe_ff;
  logic             nxt_scl_oe;
  logic             sda_oe_ff;
  logic             nxt_sda_oe;
  logic [IRQ_W-1:0] irq_st_ff;
  logic [IRQ_W-1:0] nxt_irq_st;
  logic [IRQ_W-1:0] irq_msk_ff;
  logic [IRQ_W-1:0] nxt_irq_msk;
  logic             irq_ff;
  logic             nxt_irq;
  logic             wait_ff;
  logic             nxt_wait;
  logic [31:0]      rdata_ff;
  logic [31:0]      nxt_rdata;
  logic             lvl_ff;

  logic             scl_s;
  logic             sda_s;
  logic             start_det;
  logic             stop_det;
  logic             busy;
  logic             tick;
  logic             run;
  logic             restart;

  logic             bus_req;
  logic             wr_go;
  logic [7:0]       wdat;
  logic             wr_data;
  logic             wr_own;
  logic             wr_stat;
  logic             wr_ctl;
  logic             wr_rate;
  logic             wr_irq_st;
  logic             wr_irq_msk;
  logic             st_go;
  logic [IRQ_W-1:0] ev;
  logic [2:0]       bc;

  // one byte-lane write strobe per mapped register
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [7:0] status_byte(input logic m, input logic t,
                                             input logic b, input logic p,
                                             input logic a, input logic l);
    status_byte = RST_BYTE;
    status_byte[ST_MST] = m;
    status_byte[ST_TRX] = t;
    status_byte[ST_BB]  = b;
    status_byte[ST_PIN] = p;
    status_byte[ST_AL]  = a;
    status_byte[ST_LRB] = l;
  endfunction : status_byte

  mmi_line_mon u_mon (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .scl_in        (scl_in),
    .sda_in        (sda_in),
    .scl_s_out     (scl_s),
    .sda_s_out     (sda_s),
    .start_det_out (start_det),
    .stop_det_out  (stop_det),
    .busy_out      (busy)
  );

  mmi_bit_timer u_tmr (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .restart_in (restart),
    .run_in     (run),
    .div_in     (rate_ff[RATE_DIV_W-1:0]),
    .tick_out   (tick)
  );

  // bit, ack and stop high phases wait for the clock line to really rise (stretching)
  assign run = scl_s | ~((state_ff == MMI_BIT_H) | (state_ff == MMI_ACK_H)
                         | (state_ff == MMI_STOP_H));
  assign restart = (nxt_state != state_ff);

  always_comb begin
    bus_req    = (read_in | write_in) & wait_ff;
    wr_go      = write_in & ~wait_ff & byteenable_in[0];
    wdat       = writedata_in[7:0];
    wr_data    = wr_go & hit(address_in, OFS_DATA);
    wr_own     = wr_go & hit(address_in, OFS_OWN);
    wr_stat    = wr_go & hit(address_in, OFS_STAT);
    wr_ctl     = wr_go & hit(address_in, OFS_CTRL);
    wr_rate    = wr_go & hit(address_in, OFS_RATE);
    wr_irq_st  = wr_go & hit(address_in, OFS_IRQ_ST);
    wr_irq_msk = wr_go & hit(address_in, OFS_IRQ_MSK);
    st_go      = wr_stat & wdat[ST_MST] & wdat[ST_TRX] & wdat[ST_BB] & ctl_ff[CTL_EN];

    nxt_state     = state_ff;
    nxt_shift     = shift_ff;
    nxt_own       = own_ff;
    nxt_ctl       = ctl_ff;
    nxt_rate      = rate_ff;
    nxt_mst       = mst_ff;
    nxt_trx       = trx_ff;
    nxt_pin       = pin_ff;
    nxt_al        = al_ff;
    nxt_lrb       = lrb_ff;
    nxt_stop_pend = stop_pend_ff;
    nxt_scl_oe    = scl_oe_ff;
    nxt_sda_oe    = sda_oe_ff;
    nxt_irq_msk   = irq_msk_ff;
    ev            = '0;
    bc            = ctl_ff[2:0];

    // one wait cycle, then a single-cycle answer; reads change no state
    nxt_wait  = ~bus_req;
    nxt_rdata = rdata_ff;
    if (bus_req && read_in) begin
      nxt_rdata = '0; // RULE_17
      case (address_in)
        OFS_DATA:    nxt_rdata[7:0] = shift_ff;
        OFS_OWN:     nxt_rdata[7:0] = own_ff;
        OFS_STAT:    nxt_rdata[7:0] = status_byte(mst_ff, trx_ff, busy, pin_ff, al_ff, lrb_ff);
        OFS_CTRL:    nxt_rdata[7:0] = ctl_ff;
        OFS_RATE:    nxt_rdata[7:0] = rate_ff;
        OFS_IRQ_ST:  nxt_rdata[IRQ_W-1:0] = irq_st_ff;
        OFS_IRQ_MSK: nxt_rdata[IRQ_W-1:0] = irq_msk_ff;
        default:     nxt_rdata = '0;
      endcase
    end

    // software writes first; hardware updates below override them
    if (wr_data) begin
      nxt_shift = wdat;
      nxt_pin   = 1'b1;
    end
    if (wr_own) begin
      nxt_own = wdat;
    end
    if (wr_ctl) begin
      nxt_ctl = wdat;
    end
    if (wr_rate) begin
      nxt_rate = wdat; // RULE_05
    end
    if (wr_irq_msk) begin
      nxt_irq_msk = wdat[IRQ_W-1:0];
    end
    if (wr_stat) begin
      nxt_mst = wdat[ST_MST];
      nxt_trx = wdat[ST_TRX];
      nxt_pin = wdat[ST_PIN];
      if (wdat[ST_MST] && wdat[ST_TRX] && !wdat[ST_BB] && wdat[ST_PIN]) begin
        nxt_stop_pend = 1'b1; // RULE_13
      end
      if (!wdat[ST_TRX] && state_ff == MMI_HOLD) begin
        nxt_sda_oe = 1'b0; // RULE_10
      end
    end

    if (start_det) begin
      bc = BC_ZERO; // RULE_04
    end
    if (stop_det) begin
      nxt_own[OWN_RW] = 1'b0; // RULE_02
      if (!mst_ff) begin
        ev[IRQ_SSTOP] = 1'b1; // RULE_18
      end
      // for an own stop the role ends only once the line shows it, so that stop raises no slave event
      nxt_mst = 1'b0;
      nxt_trx = 1'b0;
    end

    case (state_ff)
      MMI_IDLE, MMI_REL: begin
        if (st_go && (!busy || state_ff == MMI_REL)) begin
          nxt_state = MMI_RSETUP; // RULE_12
        end else if (stop_det) begin
          nxt_state = MMI_IDLE;
        end
      end
      MMI_RSETUP: begin
        if (tick) begin
          nxt_state  = MMI_START_H;
          nxt_sda_oe = 1'b1;
        end
      end
      MMI_START_H: begin
        if (tick) begin
          nxt_state  = MMI_START_L;
          nxt_scl_oe = 1'b1;
        end
      end
      MMI_START_L: begin
        if (tick) begin
          nxt_state  = MMI_BIT_L;
          nxt_sda_oe = trx_ff & ~shift_ff[7];
          bc         = BC_ZERO; // RULE_04
        end
      end
      MMI_BIT_L: begin
        if (tick) begin
          nxt_state  = MMI_BIT_H;
          nxt_scl_oe = 1'b0;
        end
      end
      MMI_BIT_H: begin
        if (tick) begin
          if (trx_ff && !sda_oe_ff && !sda_s) begin
            // lost arbitration: let go of the data line; the clock line is already released in this high phase
            nxt_state  = MMI_IDLE;
            nxt_al     = 1'b1;
            nxt_mst    = 1'b0;
            nxt_trx    = 1'b0;
            nxt_sda_oe = 1'b0;
            ev[IRQ_AL] = 1'b1;
          end else begin
            nxt_shift  = {shift_ff[6:0], sda_s};
            nxt_scl_oe = 1'b1;
            if (bc == BC_LAST) begin
              nxt_state  = MMI_ACK_L;
              bc         = BC_ZERO; // RULE_04
              nxt_sda_oe = ~trx_ff;
            end else begin
              nxt_state  = MMI_BIT_L;
              bc         = bc + BC_ONE;
              nxt_sda_oe = trx_ff & ~shift_ff[6];
            end
          end
        end
      end
      MMI_ACK_L: begin
        if (tick) begin
          nxt_state  = MMI_ACK_H;
          nxt_scl_oe = 1'b0;
        end
      end
      MMI_ACK_H: begin
        if (tick) begin
          nxt_state    = MMI_HOLD;
          nxt_lrb      = sda_s;
          nxt_scl_oe   = 1'b1;
          nxt_sda_oe   = 1'b0;
          nxt_pin      = 1'b0; // RULE_03
          ev[IRQ_BYTE] = 1'b1;
        end
      end
      MMI_HOLD: begin
        if (stop_pend_ff) begin
          nxt_state  = MMI_STOP_L;
          nxt_sda_oe = 1'b1;
        end else if (wr_data && mst_ff) begin
          nxt_state  = MMI_BIT_L;
          nxt_sda_oe = trx_ff & ~wdat[7];
        end else if (wr_data) begin
          nxt_state  = MMI_REL;
          nxt_scl_oe = 1'b0; // RULE_11
        end
      end
      MMI_STOP_L: begin
        if (tick) begin
          nxt_state  = MMI_STOP_H;
          nxt_scl_oe = 1'b0;
        end
      end
      MMI_STOP_H: begin
        if (tick) begin
          nxt_state     = MMI_IDLE;
          nxt_sda_oe    = 1'b0;
          nxt_stop_pend = 1'b0;
        end
      end
      default: begin
        nxt_state  = MMI_IDLE;
        nxt_scl_oe = 1'b0;
        nxt_sda_oe = 1'b0;
      end
    endcase

    if (nxt_state == MMI_IDLE) begin
      nxt_stop_pend = 1'b0;
    end
    nxt_ctl[2:0] = bc; // RULE_04
    // a new event wins over a write-one clear in the same cycle
    nxt_irq_st = (irq_st_ff & ~(wr_irq_st ? wdat[IRQ_W-1:0] : '0)) | ev;
    nxt_irq    = |(irq_st_ff & irq_msk_ff);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_ff     <= MMI_IDLE;
      shift_ff     <= RST_BYTE;
      own_ff       <= RST_BYTE;
      ctl_ff       <= RST_BYTE;
      rate_ff      <= RST_BYTE;
      mst_ff       <= 1'b0;
      trx_ff       <= 1'b0;
      pin_ff       <= 1'b1;
      al_ff        <= 1'b0;
      lrb_ff       <= 1'b0;
      stop_pend_ff <= 1'b0;
      scl_oe_ff    <= 1'b0;
      sda_oe_ff    <= 1'b0;
      irq_st_ff    <= '0;
      irq_msk_ff   <= '0;
      irq_ff       <= 1'b0;
      wait_ff      <= 1'b1;
      rdata_ff     <= '0;
      lvl_ff       <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      shift_ff     <= nxt_shift;
      own_ff       <= nxt_own;
      ctl_ff       <= nxt_ctl;
      rate_ff      <= nxt_rate;
      mst_ff       <= nxt_mst;
      trx_ff       <= nxt_trx;
      pin_ff       <= nxt_pin;
      al_ff        <= nxt_al;
      lrb_ff       <= nxt_lrb;
      stop_pend_ff <= nxt_stop_pend;
      scl_oe_ff    <= nxt_scl_oe;
      sda_oe_ff    <= nxt_sda_oe;
      irq_st_ff    <= nxt_irq_st;
      irq_msk_ff   <= nxt_irq_msk;
      irq_ff       <= nxt_irq;
      wait_ff      <= nxt_wait;
      rdata_ff     <= nxt_rdata;
      lvl_ff       <= 1'b0;
    end
  end

  // open-drain: the driven level is always low, only the enables move
  assign scl_out                   = lvl_ff;
  assign sda_out                   = lvl_ff;
  assign scl_oe_out                = scl_oe_ff;
  assign sda_oe_out                = sda_oe_ff;
  assign readdata_out              = rdata_ff;
  assign waitrequest_out           = wait_ff;
  assign bus_interrupt_request_out = irq_ff;
endmodule : mmi_ctrl

// ---- mmi_ctrl_sva.sv ----
// checker for the register handshake and the bus-line drive of the controller
`timescale 1ns/10ps
module mmi_ctrl_sva
  import mmi_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic [4:0]  address_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  input wire logic        bus_interrupt_request_out,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe_out,
  input wire logic        sda_out,
  input wire logic        sda_oe_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_taken; (read_in || write_in) && waitrequest_out; endsequence
  sequence s_start; $rose(sda_oe_out) && !scl_oe_out && scl_in; endsequence
  sequence s_rx_sel;
    write_in && !waitrequest_out && address_in == OFS_STAT && writedata_in[7:6] == 2'h0;
  endsequence
  a_req_answered: assert property (s_taken |=> !waitrequest_out)
    else $error("request not answered after one wait");
  a_ack_single: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("acknowledge lasted more than one cycle");
  a_ack_has_cause: assert property (!waitrequest_out |-> $past(read_in || write_in))
    else $error("acknowledge without a request");
  a_reset_quiet: assert property ($fell(rst_in) |-> waitrequest_out && !scl_oe_out
    && !sda_oe_out && !bus_interrupt_request_out)
    else $error("outputs not quiet after reset");
  a_open_drain: assert property (scl_out == 1'h0 && sda_out == 1'h0)
    else $error("line output level not low");
  a_read_upper: assert property (!waitrequest_out && $past(read_in) |-> readdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_start_order: assert property (s_start |-> !scl_oe_out [*8])
    else $error("clock pulled too soon after start");
  a_rx_release: assert property (s_rx_sel |-> ##[1:3] !sda_oe_out)
    else $error("data line not released after receive select");
endmodule : mmi_ctrl_sva

bind mmi_ctrl mmi_ctrl_sva u_sva (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .address_in(address_in), .read_in(read_in), .write_in(write_in),
  .writedata_in(writedata_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .bus_interrupt_request_out(bus_interrupt_request_out), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out));

// ---- mmi_bus_peer.sv ----
// other parties on the two-wire bus: pull-ups, an acking slave, a foreign master
`timescale 1ns/10ps
module mmi_bus_peer (
  input  wire logic scl_oe_in,
  input  wire logic sda_oe_in,
  input  wire logic ack_en_in,
  output logic      scl_line_out,
  output logic      sda_line_out
);
  logic peer_scl_dn;
  logic peer_sda_dn;
  int   fall_cnt;
  // wired-AND with pull-ups: a released line reads high
  assign scl_line_out = !(scl_oe_in || peer_scl_dn);
  assign sda_line_out = !(sda_oe_in || peer_sda_dn);
  initial begin
    peer_scl_dn = 1'h0;
    peer_sda_dn = 1'h0;
    fall_cnt = 0;
  end
  always @(negedge sda_line_out) if (scl_line_out) fall_cnt = 0;
  // ninth low phase after a start is the ack slot
  always @(negedge scl_line_out) begin
    fall_cnt = fall_cnt + 1;
    if (fall_cnt == 9) peer_sda_dn = ack_en_in;
    if (fall_cnt == 10) begin
      peer_sda_dn = 1'h0;
      fall_cnt = 1;
    end
  end
  // clock runs at 200 ns only inside the frame
  task automatic foreign_frame();
    // offset keeps line changes off the sampling clock edge
    #110 peer_sda_dn = 1'h1;
    #500 peer_scl_dn = 1'h1;
    repeat (2) begin
      #100 peer_scl_dn = 1'h0;
      #100 peer_scl_dn = 1'h1;
    end
    #100 peer_scl_dn = 1'h0;
    #500 peer_sda_dn = 1'h0;
  endtask : foreign_frame
endmodule : mmi_bus_peer

// ---- tb_top.sv ----
// bench: register sequences for start, restart, stop and foreign bus traffic
`timescale 1ns/10ps
module tb_top
  import mmi_pkg::*;
;
  logic        ref_clk_in;
  logic        rst_in;
  logic [4:0]  address_in;
  logic        read_in;
  logic        write_in;
  logic [31:0] writedata_in;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic        irq_out;
  logic        scl_w, sda_w, scl_out, sda_out, scl_oe_out, sda_oe_out;
  logic        ack_on;
  logic [8:0]  wire_bits;
  logic [7:0]  rd;
  int          miscompares, checks_done, stops_seen, s0;

  initial ref_clk_in = 1'h0;
  always #12.5 ref_clk_in = ~ref_clk_in;

  mmi_ctrl DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(4'hF),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .bus_interrupt_request_out(irq_out), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
  mmi_bus_peer u_peer (.scl_oe_in(scl_oe_out), .sda_oe_in(sda_oe_out), .ack_en_in(ack_on),
    .scl_line_out(scl_w), .sda_line_out(sda_w));

  // last nine bits on the wire: byte MSB first, then ack
  always @(posedge scl_w) wire_bits <= {wire_bits[7:0], sda_w};
  always @(posedge sda_w) if (scl_w === 1'h1) stops_seen++;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic tick(inout int n, input int lim);
    n++;
    if (n > lim) begin
      miscompares++;
      stop_test();
    end
  endtask : tick

  // request held until waitrequest is sampled low, then released
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address_in   <= a;
    writedata_in <= {24'h0, d};
    write_in     <= wr;
    read_in      <= !wr;
    @(posedge ref_clk_in);
    while (waitrequest_out !== 1'h0) begin
      tick(n, 20);
      @(posedge ref_clk_in);
    end
    rd = readdata_out[7:0];
    write_in <= 1'h0;
    read_in  <= 1'h0;
    @(posedge ref_clk_in);
  endtask : bus_xfer

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_out !== 1'h1) begin
      tick(n, 3000);
      @(posedge ref_clk_in);
    end
  endtask : wait_irq

  task automatic wait_free();
    int n;
    n = 0;
    rd = 8'hFF;
    while (rd[ST_BB] !== 1'h0) begin
      tick(n, 200);
      bus_xfer(1'h0, OFS_STAT, 8'h00);
    end
  endtask : wait_free

  initial begin
    rst_in = 1'h1;
    read_in = 1'h0;
    write_in = 1'h0;
    address_in = 5'h0;
    writedata_in = 32'h0;
    ack_on = 1'h1;
    miscompares = 0;
    checks_done = 0;
    stops_seen = 0;
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    @(posedge ref_clk_in);
    bus_xfer(1'h0, OFS_STAT, 8'h00);
    check("status reset", rd, 8'h10);
    bus_xfer(1'h1, 5'h1C, 8'h5A);
    bus_xfer(1'h0, 5'h1C, 8'h00);
    check("unmapped", rd, 8'h00);
    bus_xfer(1'h1, OFS_RATE, 8'h05);
    bus_xfer(1'h0, OFS_RATE, 8'h00);
    bus_xfer(1'h1, OFS_RATE, rd | 8'h08);
    bus_xfer(1'h0, OFS_RATE, 8'h00);
    check("rate rmw", rd, 8'h0D);
    bus_xfer(1'h1, OFS_RATE, 8'h00);
    $display("test registers done");
    bus_xfer(1'h1, OFS_CTRL, 8'h08);
    bus_xfer(1'h1, OFS_OWN, 8'h01);
    bus_xfer(1'h1, OFS_IRQ_MSK, 8'h02);
    fork
      u_peer.foreign_frame();
      begin
        repeat (30) @(posedge ref_clk_in);
        bus_xfer(1'h0, OFS_STAT, 8'h00);
        check("busy in frame", {7'h0, rd[ST_BB]}, 8'h01);
      end
    join
    repeat (10) @(posedge ref_clk_in);
    check("stop irq", {7'h0, irq_out}, 8'h01);
    bus_xfer(1'h0, OFS_STAT, 8'h00);
    check("busy after stop", {7'h0, rd[ST_BB]}, 8'h00);
    bus_xfer(1'h0, OFS_OWN, 8'h00);
    check("rw match", {7'h0, rd[OWN_RW]}, 8'h00);
    bus_xfer(1'h1, OFS_IRQ_MSK, 8'h00);
    repeat (2) @(posedge ref_clk_in);
    check("irq masked", {7'h0, irq_out}, 8'h00);
    bus_xfer(1'h0, OFS_IRQ_ST, 8'h00);
    check("irq status", rd, 8'h02);
    bus_xfer(1'h1, OFS_IRQ_ST, 8'h02);
    bus_xfer(1'h0, OFS_IRQ_ST, 8'h00);
    check("irq cleared", rd, 8'h00);
    $display("test slave stop done");
    bus_xfer(1'h1, OFS_IRQ_MSK, 8'h01);
    bus_xfer(1'h0, OFS_STAT, 8'h00);
    check("bus free", {7'h0, rd[ST_BB]}, 8'h00);
    bus_xfer(1'h1, OFS_DATA, 8'hA4);
    bus_xfer(1'h1, OFS_STAT, 8'hF0);
    wait_irq();
    check("address bits", wire_bits[8:1], 8'hA4);
    check("ack bit", {7'h0, wire_bits[0]}, 8'h00);
    bus_xfer(1'h0, OFS_STAT, 8'h00);
    check("master status", rd, 8'hE0);
    bus_xfer(1'h0, OFS_CTRL, 8'h00);
    check("bit count", rd, 8'h08);
    bus_xfer(1'h1, OFS_IRQ_ST, 8'h01);
    $display("test start done");
    bus_xfer(1'h1, OFS_STAT, 8'h00);
    repeat (2) @(posedge ref_clk_in);
    check("sda released", {7'h0, sda_oe_out}, 8'h00);
    check("scl held", {7'h0, scl_oe_out}, 8'h01);
    bus_xfer(1'h0, OFS_STAT, 8'h00);
    check("role and direction", {6'h0, rd[ST_MST:ST_TRX]}, 8'h00);
    bus_xfer(1'h1, OFS_DATA, 8'h5B);
    check("scl released", {6'h0, scl_oe_out, scl_w}, 8'h01);
    bus_xfer(1'h1, OFS_STAT, 8'hF0);
    wait_irq();
    check("restart bits", wire_bits[8:1], 8'h5B);
    bus_xfer(1'h1, OFS_IRQ_ST, 8'h01);
    $display("test restart done");
    s0 = stops_seen;
    bus_xfer(1'h1, OFS_STAT, 8'hC0);
    bus_xfer(1'h1, OFS_STAT, 8'hD0);
    wait_free();
    check("stop on wire", 8'(stops_seen - s0), 8'h01);
    bus_xfer(1'h0, OFS_IRQ_ST, 8'h00);
    check("own stop no slave irq", rd, 8'h00);
    $display("test stop done");
    stop_test();
  end
endmodule : tb_top
